// *** include/lcb_pkg.sv ***
package lcb_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int CTR_NUM_DEF = 128;
	localparam int PM_WORDS_DEF = 64;
	// Data memory locations are octal words: current values at octal 1000
	localparam logic [ADDR_W-1:0] CUR_BASE = 12'h200;
	// Preset words start at octal 1200
	localparam logic [ADDR_W-1:0] PM_BASE = 12'h280;
	localparam logic [ADDR_W-1:0] CFG_BASE = 12'h800;
	localparam logic [ADDR_W-1:0] KPRE_BASE = 12'h900;
	localparam logic [ADDR_W-1:0] DONE_BASE = 12'ha00;
	localparam logic [ADDR_W-1:0] STAT_ADDR = 12'hb00;
	localparam logic [15:0] STAGE_MAX = 16'h9999;
	localparam logic [31:0] UDC_MAX = 32'h99999999;
	localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

	typedef enum logic [1:0] {K_OFF, K_BASIC, K_STAGE, K_UDC} lcb_kind_t;
	typedef enum logic {ST_IDLE, ST_WALK} lcb_state_t;

	typedef struct packed {
		logic [7:0] pm_idx;
		logic [4:0] rsvd;
		logic       from_mem;
		lcb_kind_t  kind;
	} lcb_cfg_t;

	localparam lcb_cfg_t CFG_RST = 16'h0000;
endpackage

// *** hw/lcb_bcd_step.sv ***
`timescale 1ns/1ps
module lcb_bcd_step #(
	parameter int DIGITS = 8
) (
	input  wire logic [4*DIGITS-1:0] value_i,
	input  wire logic [4*DIGITS-1:0] limit_i,
	input  wire logic                inc_i,
	input  wire logic                dec_i,
	output logic      [4*DIGITS-1:0] value_o
);
	logic [DIGITS:0]     carry;
	logic [4*DIGITS-1:0] raw;

	generate
		if (DIGITS < 1) begin : g_bad_digits
			$error("DIGITS must be at least 1");
		end
	endgenerate

	assign carry[0] = inc_i | dec_i;

	generate
		for (genvar d = 0; d < DIGITS; d++) begin : g_dig
			logic [3:0] dig;
			assign dig = value_i[4*d +: 4];
			assign carry[d+1] = carry[d] & (inc_i ? (dig == 4'h9) : (dig == 4'h0));
			assign raw[4*d +: 4] = !carry[d] ? dig :
				inc_i ? ((dig == 4'h9) ? 4'h0 : dig + 4'h1) :
				((dig == 4'h0) ? 4'h9 : dig - 4'h1);
		end
	endgenerate

	// Saturate at the ceiling and at zero instead of wrapping
	assign value_o = ((inc_i && (value_i >= limit_i)) || (dec_i && (value_i == '0))) ? value_i : raw;
endmodule // lcb_bcd_step

// *** hw/lcb_done_eval.sv ***
`timescale 1ns/1ps
module lcb_done_eval (
	input  wire logic [31:0] count_i,
	input  wire logic        from_mem_i,
	input  wire logic        wide_i,
	input  wire logic [15:0] mem_lo_i,
	input  wire logic [15:0] mem_hi_i,
	input  wire logic [15:0] k_lo_i,
	input  wire logic [15:0] k_hi_i,
	output logic             done_o
);
	logic [31:0] preset;

	assign preset = from_mem_i ? {(wide_i ? mem_hi_i : 16'h0000), mem_lo_i}
		: {(wide_i ? k_hi_i : 16'h0000), k_lo_i};
	// Valid packed decimal orders the same as binary
	assign done_o = (count_i >= preset);
endmodule // lcb_done_eval

// *** hw/lcb_counter_bank.sv ***
`timescale 1ns/1ps
module lcb_counter_bank
	import lcb_pkg::*;
#(
	parameter int CTR_NUM  = CTR_NUM_DEF,
	parameter int PM_WORDS = PM_WORDS_DEF
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       scan_i,
	input  wire logic [CTR_NUM-1:0]         up_i,
	input  wire logic [CTR_NUM-1:0]         down_i,
	input  wire logic [CTR_NUM-1:0]         reset_in_i,
	input  wire logic                       stage_rst_i,
	input  wire logic [$clog2(CTR_NUM)-1:0] stage_rst_idx_i,
	input  wire logic [ADDR_W-1:0]          addr_i,
	input  wire logic [DATA_W-1:0]          wdata_i,
	input  wire logic                       we_i,
	input  wire logic                       re_i,
	output logic      [DATA_W-1:0]          rdata_o,
	output logic      [CTR_NUM-1:0]         done_o,
	output logic                            busy_o
);
	localparam int IDX_W = $clog2(CTR_NUM);
	localparam int PM_IW = $clog2(PM_WORDS);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CTR_NUM - 1);
	localparam int DONE_WORDS = (CTR_NUM + 15) / 16;

	generate
		// Count words must end below the preset block and preset words must be aligned to their own size, which caps both at 128
		if ((CTR_NUM < 2) || (CTR_NUM > 128) || ((1 << IDX_W) != CTR_NUM)) begin : g_bad_num
			$error("CTR_NUM must be a power of two from 2 to 128");
		end
		if ((PM_WORDS < 2) || (PM_WORDS > 128) || ((1 << PM_IW) != PM_WORDS)) begin : g_bad_pm
			$error("PM_WORDS must be a power of two from 2 to 128");
		end
	endgenerate

	logic [DATA_W-1:0] cur_mem [CTR_NUM];
	lcb_cfg_t          cfg_mem [CTR_NUM];
	logic [DATA_W-1:0] kpre_mem[CTR_NUM];
	logic [DATA_W-1:0] pm_mem  [PM_WORDS];

	lcb_state_t        state;
	logic [IDX_W-1:0]  idx;
	logic [CTR_NUM-1:0] samp_up;
	logic [CTR_NUM-1:0] samp_dn;
	logic [CTR_NUM-1:0] samp_rs;
	logic [CTR_NUM-1:0] prev_up;
	logic [CTR_NUM-1:0] prev_dn;
	logic [CTR_NUM-1:0] stage_pend;

	logic [IDX_W-1:0]  next_idx;
	lcb_cfg_t          cfg_cur;
	logic              walking;
	logic              active;
	logic              wide;
	logic              rise_up;
	logic              rise_dn;
	logic              inc;
	logic              dec;
	logic              clr;
	logic [31:0]       cur_val;
	logic [31:0]       limit;
	logic [31:0]       step_val;
	logic [31:0]       next_val;
	logic [PM_IW-1:0]  pm_lo_idx;
	logic [PM_IW-1:0]  pm_hi_idx;
	logic              next_done;
	lcb_cfg_t          cfg_wr;
	logic              hit_cur;
	logic              hit_pm;
	logic              hit_cfg;
	logic              hit_kpre;
	logic              hit_done;
	logic [16*DONE_WORDS-1:0] done_pad;
	logic [DATA_W-1:0] done_word;

	assign walking = (state == ST_WALK);
	assign next_idx = idx + IDX_W'(1);
	assign cfg_cur = cfg_mem[idx];
	assign active  = walking && (cfg_cur.kind != K_OFF);
	// The last counter number has no partner word, so an up/down there is four digits only
	assign wide    = (cfg_cur.kind == K_UDC) && (idx != LAST_IDX);
	assign cur_val = {(wide ? cur_mem[next_idx] : 16'h0000), cur_mem[idx]};
	assign rise_up = samp_up[idx] & ~prev_up[idx];
	assign rise_dn = samp_dn[idx] & ~prev_dn[idx];
	assign limit   = wide ? UDC_MAX : {16'h0000, STAGE_MAX};
	assign pm_lo_idx = cfg_cur.pm_idx[PM_IW-1:0];
	assign pm_hi_idx = pm_lo_idx + PM_IW'(1);

	assign hit_cur  = (addr_i[ADDR_W-1:IDX_W] == CUR_BASE[ADDR_W-1:IDX_W]);
	assign hit_pm   = (addr_i[ADDR_W-1:PM_IW] == PM_BASE[ADDR_W-1:PM_IW]);
	assign hit_cfg  = (addr_i[ADDR_W-1:IDX_W] == CFG_BASE[ADDR_W-1:IDX_W]);
	assign hit_kpre = (addr_i[ADDR_W-1:IDX_W] == KPRE_BASE[ADDR_W-1:IDX_W]);
	assign hit_done = (addr_i[ADDR_W-1:8] == DONE_BASE[ADDR_W-1:8]);
	assign done_pad = (16*DONE_WORDS)'(done_o);

	always_comb begin
		inc = 1'b0;
		dec = 1'b0;
		clr = 1'b0;
		case (cfg_cur.kind)
			K_BASIC: begin
				inc = rise_up;
				clr = samp_rs[idx];
			end
			K_STAGE: begin
				inc = rise_up;
				clr = stage_pend[idx];
			end
			K_UDC: begin
				inc = rise_up & ~samp_dn[idx];
				dec = rise_dn & ~samp_up[idx];
				clr = samp_rs[idx];
			end
			default: begin
				inc = 1'b0;
			end
		endcase
	end

	lcb_bcd_step #(
		.DIGITS (8)
	) u_step (
		.value_i (cur_val),
		.limit_i (limit),
		.inc_i   (inc),
		.dec_i   (dec),
		.value_o (step_val)
	);

	assign next_val = clr ? 32'h00000000 : step_val;

	lcb_done_eval u_done (
		.count_i    (next_val),
		.from_mem_i (cfg_cur.from_mem),
		.wide_i     (wide),
		.mem_lo_i   (pm_mem[pm_lo_idx]),
		.mem_hi_i   (pm_mem[pm_hi_idx]),
		.k_lo_i     (kpre_mem[idx]),
		.k_hi_i     (kpre_mem[next_idx]),
		.done_o     (next_done)
	);

	// Scan sequencer: one counter per clock, so a scan takes CTR_NUM cycles
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			idx   <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (scan_i) begin
						state <= ST_WALK;
						idx   <= '0;
					end
				end
				ST_WALK: begin
					idx <= next_idx;
					if (idx == LAST_IDX) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Inputs are frozen for the whole walk so every counter sees one coherent scan
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			samp_up <= '0;
			samp_dn <= '0;
			samp_rs <= '0;
			prev_up <= '0;
			prev_dn <= '0;
		end else if (!walking && scan_i) begin
			prev_up <= samp_up;
			prev_dn <= samp_dn;
			samp_up <= up_i;
			samp_dn <= down_i;
			samp_rs <= reset_in_i;
		end
	end

	generate
		for (genvar n = 0; n < CTR_NUM; n++) begin : g_pend
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i) begin
					stage_pend[n] <= 1'b0;
				end else if (stage_rst_i && (stage_rst_idx_i == IDX_W'(n))) begin
					stage_pend[n] <= 1'b1;
				end else if (walking && (idx == IDX_W'(n))) begin
					stage_pend[n] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CTR_NUM; i++) begin
				cur_mem[i] <= RST_WORD;
			end
			done_o <= '0;
		end else if (active) begin
			cur_mem[idx] <= next_val[15:0];
			if (wide) begin
				cur_mem[next_idx] <= next_val[31:16];
			end
			done_o[idx] <= next_done;
		end
	end

	// Reserved configuration bits are dropped on write so they always read zero
	always_comb begin
		cfg_wr          = CFG_RST;
		cfg_wr.pm_idx   = wdata_i[15:8];
		cfg_wr.from_mem = wdata_i[2];
		cfg_wr.kind     = lcb_kind_t'(wdata_i[1:0]);
	end

	// Done bits read sixteen to a word; words past the bank read zero
	always_comb begin
		done_word = 16'h0000;
		for (int w = 0; w < DONE_WORDS; w++) begin
			if (addr_i[7:0] == 8'(w)) begin
				done_word = done_pad[16*w +: 16];
			end
		end
	end

	// Software side: configuration, constant presets and preset memory
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CTR_NUM; i++) begin
				cfg_mem[i]  <= CFG_RST;
				kpre_mem[i] <= RST_WORD;
			end
			for (int j = 0; j < PM_WORDS; j++) begin
				pm_mem[j] <= RST_WORD;
			end
		end else if (we_i) begin
			if (hit_cfg) begin
				cfg_mem[addr_i[IDX_W-1:0]] <= cfg_wr;
			end
			if (hit_kpre) begin
				kpre_mem[addr_i[IDX_W-1:0]] <= wdata_i;
			end
			if (hit_pm) begin
				pm_mem[addr_i[PM_IW-1:0]] <= wdata_i;
			end
		end
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= RST_WORD;
		end else if (!re_i) begin
			rdata_o <= RST_WORD;
		end else if (hit_cur) begin
			rdata_o <= cur_mem[addr_i[IDX_W-1:0]];
		end else if (hit_pm) begin
			rdata_o <= pm_mem[addr_i[PM_IW-1:0]];
		end else if (hit_cfg) begin
			rdata_o <= cfg_mem[addr_i[IDX_W-1:0]];
		end else if (hit_kpre) begin
			rdata_o <= kpre_mem[addr_i[IDX_W-1:0]];
		end else if (hit_done) begin
			rdata_o <= done_word;
		end else if (addr_i == STAT_ADDR) begin
			rdata_o <= {15'h0000, walking};
		end else begin
			rdata_o <= RST_WORD;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= walking ? (idx != LAST_IDX) : scan_i;
		end
	end
endmodule // lcb_counter_bank

// *** verif/lcb_counter_bank_sva.sv ***
`timescale 1ns/1ps
module lcb_counter_bank_sva
	import lcb_pkg::*;
#(
	parameter int CTR_NUM = CTR_NUM_DEF
) (
	input wire logic               ref_clk_i,
	input wire logic               rst_i,
	input wire logic               scan_i,
	input wire logic [ADDR_W-1:0]  addr_i,
	input wire logic               re_i,
	input wire logic [DATA_W-1:0]  rdata_o,
	input wire logic [CTR_NUM-1:0] done_o,
	input wire logic               busy_o
);
	int busy_cnt;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Counts walk length so the check holds for any bank size
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) busy_cnt <= 0;
		else busy_cnt <= busy_o ? busy_cnt + 1 : 0;
	end
	sequence take_s;
		scan_i && !busy_o;
	endsequence
	sequence rd_s(logic [ADDR_W-1:0] a);
		re_i && addr_i == a;
	endsequence
	take_busy_a: assert property (take_s |=> busy_o) else $error("scan not taken");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(scan_i)) else $error("walk without scan");
	busy_len_a: assert property ($fell(busy_o) |-> busy_cnt == CTR_NUM) else $error("walk length wrong");
	read_idle_a: assert property (!re_i |=> rdata_o == '0) else $error("read data not cleared");
	status_rd_a: assert property (rd_s(STAT_ADDR) |=> rdata_o == {15'h0, $past(busy_o)}) else $error("bad status");
	unmapped_rd_a: assert property (rd_s(12'hc00) |=> rdata_o == '0) else $error("unmapped read not zero");
	done_rd_a: assert property (rd_s(DONE_BASE) |=> rdata_o[3:0] == $past(done_o[3:0])) else $error("done word");
	done_hold_a: assert property (!busy_o && !$past(busy_o) |-> $stable(done_o)) else $error("done moved");
	done0_time_a: assert property ($changed(done_o[0]) |-> $past(scan_i, 2)) else $error("done0 late");
endmodule // lcb_counter_bank_sva
bind lcb_counter_bank lcb_counter_bank_sva #(.CTR_NUM(CTR_NUM)) u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.scan_i(scan_i), .addr_i(addr_i), .re_i(re_i), .rdata_o(rdata_o), .done_o(done_o), .busy_o(busy_o));

// *** verif/lcb_prog_model.sv ***
`timescale 1ns/1ps
module lcb_prog_model #(
	parameter int         CTR_NUM  = 4,
	parameter logic [3:0] UDC_MASK = 4'h4
) (
	input  wire logic               ref_clk_i,
	output logic                    scan_o,
	output logic      [CTR_NUM-1:0] up_o,
	output logic      [CTR_NUM-1:0] down_o,
	output logic      [CTR_NUM-1:0] reset_in_o
);
	initial begin
		scan_o = 0;
		up_o = '0;
		down_o = '0;
		reset_in_o = '0;
	end
	// Levels stand for the whole scan, one sample each
	task run(input logic [CTR_NUM-1:0] u, d, r);
		@(posedge ref_clk_i);
		up_o <= u;
		down_o <= d & ~(u & UDC_MASK);
		reset_in_o <= r;
		scan_o <= 1;
		@(posedge ref_clk_i);
		scan_o <= 0;
		repeat (CTR_NUM + 1) @(posedge ref_clk_i);
	endtask
endmodule // lcb_prog_model

// *** verif/lcb_counter_bank_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module lcb_counter_bank_tb
	import lcb_pkg::*;
;
	localparam int N = 4;
	logic              ref_clk_i = 0, rst_i = 1, stage_rst_i = 0, we_i = 0, re_i = 0, busy_o, scan_i;
	logic [1:0]        stage_rst_idx_i = '0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0, rdata_o;
	logic [N-1:0]      up_i, down_i, reset_in_i, done_o, u, dn, r, ed;
	int                failures = 0, num_checks = 0, c[N], pre[3] = '{3, 5, 2};
	bit   [N-1:0]      pu, pd;
	bit                pend;
	always #25 ref_clk_i = ~ref_clk_i;
	lcb_counter_bank #(.CTR_NUM(N), .PM_WORDS(4)) u_lcb_counter_bank (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.scan_i(scan_i), .up_i(up_i), .down_i(down_i), .reset_in_i(reset_in_i), .stage_rst_i(stage_rst_i),
		.stage_rst_idx_i(stage_rst_idx_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
		.rdata_o(rdata_o), .done_o(done_o), .busy_o(busy_o));
	lcb_prog_model #(.CTR_NUM(N)) u_lcb_prog_model (.ref_clk_i(ref_clk_i), .scan_o(scan_i), .up_o(up_i),
		.down_o(down_i), .reset_in_o(reset_in_i));
	function automatic logic [15:0] bcd(int v);
		for (int i = 0; i < 4; i++) begin
			bcd[4*i+:4] = 4'(v % 10);
			v = v / 10;
		end
	endfunction
	task wr(input logic [11:0] a, input logic [15:0] w);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= w;
		we_i <= 1;
		@(posedge ref_clk_i);
		we_i <= 0;
	endtask
	task rc(input logic [11:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		re_i <= 1;
		@(posedge ref_clk_i);
		re_i <= 0;
		@(negedge ref_clk_i);
		`CHK(rdata_o, e)
	endtask
	task summarize;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(32'hf5fe));
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 0;
		wr(12'h900, 16'h0003);
		wr(12'h280, 16'h0005);
		wr(12'h902, 16'h0002);
		wr(12'h903, 16'h0000);
		wr(12'h800, 16'h0001);
		wr(12'h801, 16'h0006);
		wr(12'h802, 16'h0003);
		wr(12'h803, 16'h00f8);
		rc(12'h803, 16'h0000);
		rc(12'h801, 16'h0006);
		wr(12'h200, 16'h1234);
		rc(12'h200, 16'h0000);
		rc(12'hc00, 16'h0000);
		$display("test config done");
		for (int s = 0; s < 80; s++) begin
			if (s == 40) begin
				wr(12'h900, 16'h0007);
				pre[0] = 7;
			end
			u = 4'($urandom);
			dn = 4'($urandom);
			r = 4'($urandom & $urandom & $urandom);
			// No count edge on the stage counter while a reset command is pending
			if (s % 9 == 8) begin
				u[1] = 0;
				pend = 1;
				@(posedge ref_clk_i);
				stage_rst_idx_i <= 2'd1;
				stage_rst_i <= 1;
				@(posedge ref_clk_i);
				stage_rst_i <= 0;
			end
			dn[2] = dn[2] & ~u[2];
			// Busy and the status word are looked at in mid walk, then busy alone after it ends
			fork
				u_lcb_prog_model.run(u, dn, r);
				begin
					repeat (3) @(posedge ref_clk_i);
					@(negedge ref_clk_i);
					`CHK(busy_o, 1'b1)
					rc(STAT_ADDR, 16'h0001);
					@(negedge ref_clk_i);
					`CHK(busy_o, 1'b0)
				end
			join
			if (r[0]) c[0] = 0;
			else if (u[0] && !pu[0] && c[0] < 9999) c[0]++;
			if (pend) c[1] = 0;
			else if (u[1] && !pu[1] && c[1] < 9999) c[1]++;
			pend = 0;
			if (r[2]) c[2] = 0;
			else if (u[2] && !pu[2]) c[2]++;
			else if (dn[2] && !pd[2] && c[2] > 0) c[2]--;
			pu = u;
			pd = dn;
			ed = {1'b0, 1'(c[2] >= pre[2]), 1'(c[1] >= pre[1]), 1'(c[0] >= pre[0])};
			rc(12'h200, bcd(c[0]));
			rc(12'h201, bcd(c[1]));
			rc(12'h202, bcd(c[2]));
			rc(12'h203, bcd(c[2] / 10000));
			`CHK(done_o, ed)
			rc(DONE_BASE, {12'h000, ed});
		end
		$display("test scans done");
		summarize();
	end
endmodule // lcb_counter_bank_tb
